// *** rtl/efh_pkg.sv ***
// Constants for the Ethernet frame handling block: register map,
// field positions, reset values, frame sizes and framing bytes.
// Assumes a 32-bit classic Wishbone register bus and byte-wide medium.
`default_nettype none
package efh_pkg;
   // Register byte offsets
   localparam logic [3:0] ADR_CTRL    = 4'h0;
   localparam logic [3:0] ADR_FILTER  = 4'h4;
   localparam logic [3:0] ADR_RX_STAT = 4'h8;
   localparam logic [3:0] ADR_TX_STAT = 4'hC;
   // Control fields: mac_control_three
   localparam int CTRL_PAD_LSB = 0;   // pad_crc_config <2:0>
   localparam int CTRL_HUGE    = 3;   // huge_frame_enable
   localparam logic [3:0] CTRL_RST = 4'h0;
   // receive_filter_control fields
   localparam int FLT_UC  = 0;
   localparam int FLT_MC  = 1;
   localparam int FLT_BC  = 2;
   localparam int FLT_CRC = 3;        // crc_check_filter_enable
   localparam logic [3:0] FLT_RST = 4'hF;
   // Receive status vector fields
   localparam int RS_CRC_OK = 16;
   localparam int RS_MC     = 17;
   localparam int RS_BC     = 18;
   localparam int RS_LENFLD = 19;
   localparam int RS_KEEP   = 20;
   localparam int RS_RUNT   = 21;
   // Framing bytes and counts
   localparam logic [7:0]  PRE_BYTE  = 8'h55;
   localparam logic [7:0]  SFD_BYTE  = 8'hD5;
   localparam logic [2:0]  PRE_LEN   = 3'h7;
   localparam logic [15:0] MIN_NOFCS = 16'h003C;   // 60
   localparam logic [15:0] MIN_RX    = 16'h0012;   // 18
   localparam logic [15:0] MAX_DATA  = 16'h05DC;   // 1500
   localparam logic [15:0] HDR_LEN   = 16'h000E;   // 14
   localparam logic [15:0] FCS_LEN   = 16'h0004;
   localparam logic [1:0]  FCS_LAST  = 2'h3;
   // CRC-32, reflected form
   localparam logic [31:0] CRC_INIT  = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY  = 32'hEDB8_8320;
   localparam logic [31:0] CRC_RESID = 32'hDEBB_20E3;

   typedef enum logic [2:0] {
      EFH_T_IDLE  = 3'b000,
      EFH_T_PRE   = 3'b001,
      EFH_T_SFD   = 3'b010,
      EFH_T_DATA  = 3'b011,
      EFH_T_PAD   = 3'b100,
      EFH_T_FCS   = 3'b101,
      EFH_T_DRAIN = 3'b110
   } efh_tx_st_t;

   typedef enum logic [1:0] {
      EFH_R_IDLE = 2'b00,
      EFH_R_PRE  = 2'b01,
      EFH_R_DATA = 2'b10,
      EFH_R_DROP = 2'b11
   } efh_rx_st_t;

   // One byte into the running CRC
   function automatic logic [31:0] efh_crc_byte(input logic [31:0] c,
                                                input logic [7:0]  d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// *** rtl/efh_frame.sv ***
// Ethernet frame handling: transmit framing, padding and CRC, receive
// stripping, size and CRC checks, address classing and filtering.
// Assumes medium byte streams and the buffer ports share i_sys_clk.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`default_nettype none
module efh_frame (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic [3:0]  i_wb_sel,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_txs_valid,
   input  wire logic [7:0]  i_txs_data,
   input  wire logic        i_txs_last,
   output logic             o_txs_ready,
   output logic             o_tx_en,
   output logic      [7:0]  o_txd,
   input  wire logic        i_rx_dv,
   input  wire logic [7:0]  i_rxd,
   output logic             o_rxb_valid,
   output logic      [7:0]  o_rxb_data,
   output logic             o_rxb_done,
   output logic             o_rxb_keep
);
   logic [3:0]  ctrl_q;
   logic [3:0]  filt_q;
   logic [21:0] rx_stat_q;
   logic        tx_trunc_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        pad_en;
   logic        crc_en;
   logic        huge;
   logic        wb_req;

   assign pad_en = ctrl_q[efh_pkg::CTRL_PAD_LSB];
   assign crc_en = ctrl_q[efh_pkg::CTRL_PAD_LSB +: 3] != 3'h0;
   assign huge   = ctrl_q[efh_pkg::CTRL_HUGE];
   assign wb_req = i_wb_cyc & i_wb_stb & ~ack_q;

   // Bus answer: one wait state, ack for one cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_req;
      end
   end

   // Writable registers, loaded at the acked edge; low byte lane only
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         ctrl_q <= efh_pkg::CTRL_RST;
         filt_q <= efh_pkg::FLT_RST;
      end else if (ack_q && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0]) begin
         if (i_wb_adr == efh_pkg::ADR_CTRL) begin
            ctrl_q <= i_wb_dat[3:0];
         end else if (i_wb_adr == efh_pkg::ADR_FILTER) begin
            filt_q <= i_wb_dat[3:0];
         end
      end
   end

   // Read data, unmapped offsets read zero
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         rdat_q <= 32'h0000_0000;
      end else if (wb_req) begin
         if (i_wb_adr == efh_pkg::ADR_CTRL) begin
            rdat_q <= {28'h000_0000, ctrl_q};
         end else if (i_wb_adr == efh_pkg::ADR_FILTER) begin
            rdat_q <= {28'h000_0000, filt_q};
         end else if (i_wb_adr == efh_pkg::ADR_RX_STAT) begin
            rdat_q <= {10'h000, rx_stat_q};
         end else if (i_wb_adr == efh_pkg::ADR_TX_STAT) begin
            rdat_q <= {30'h0000_0000, tx_trunc_q, o_tx_en};
         end else begin
            rdat_q <= 32'h0000_0000;
         end
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   // ---------------- Transmit ----------------
   efh_pkg::efh_tx_st_t tx_st_q;
   logic [15:0] tx_cnt_q;
   logic [2:0]  pre_cnt_q;
   logic [1:0]  fcs_cnt_q;
   logic [31:0] tx_crc_q;
   logic        tx_fire;
   logic [15:0] tx_max;
   logic [15:0] tx_next;

   // Source is drained in drain state so a cut frame never wedges it
   assign o_txs_ready = (tx_st_q == efh_pkg::EFH_T_SFD) ||
                        (tx_st_q == efh_pkg::EFH_T_DATA) ||
                        (tx_st_q == efh_pkg::EFH_T_DRAIN);
   assign tx_fire = o_txs_ready & i_txs_valid;
   assign tx_next = tx_cnt_q + 16'h0001;
   // Bytes before CRC; host-supplied CRC rides inside the stream
   assign tx_max  = efh_pkg::HDR_LEN + efh_pkg::MAX_DATA +
                    (crc_en ? 16'h0000 : efh_pkg::FCS_LEN);

   // Transmit sequencer; one idle cycle between frames
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         tx_st_q    <= efh_pkg::EFH_T_IDLE;
         tx_cnt_q   <= 16'h0000;
         pre_cnt_q  <= 3'h0;
         fcs_cnt_q  <= 2'h0;
         tx_crc_q   <= efh_pkg::CRC_INIT;
         o_tx_en    <= 1'b0;
         o_txd      <= 8'h00;
         tx_trunc_q <= 1'b0;
      end else begin
         case (tx_st_q)
            efh_pkg::EFH_T_IDLE: begin
               o_tx_en  <= 1'b0;
               o_txd    <= 8'h00;
               tx_cnt_q <= 16'h0000;
               tx_crc_q <= efh_pkg::CRC_INIT;
               if (i_txs_valid && !o_tx_en) begin
                  tx_st_q    <= efh_pkg::EFH_T_PRE;
                  o_tx_en    <= 1'b1;
                  o_txd      <= efh_pkg::PRE_BYTE;
                  pre_cnt_q  <= 3'h1;
                  tx_trunc_q <= 1'b0;
               end
            end
            efh_pkg::EFH_T_PRE: begin
               if (pre_cnt_q == efh_pkg::PRE_LEN) begin
                  o_txd   <= efh_pkg::SFD_BYTE;
                  tx_st_q <= efh_pkg::EFH_T_SFD;
               end else begin
                  o_txd     <= efh_pkg::PRE_BYTE;
                  pre_cnt_q <= pre_cnt_q + 3'h1;
               end
            end
            efh_pkg::EFH_T_SFD,
            efh_pkg::EFH_T_DATA: begin
               // Host bytes go out verbatim: addresses are never inserted
               if (tx_fire) begin
                  o_txd    <= i_txs_data;
                  tx_cnt_q <= tx_next;
                  tx_crc_q <= efh_pkg::efh_crc_byte(tx_crc_q, i_txs_data);
                  tx_st_q  <= efh_pkg::EFH_T_DATA;
                  if (!huge && tx_cnt_q >= tx_max) begin
                     o_tx_en    <= 1'b0;
                     tx_trunc_q <= 1'b1;
                     tx_st_q    <= i_txs_last ? efh_pkg::EFH_T_IDLE
                                              : efh_pkg::EFH_T_DRAIN;
                  end else if (i_txs_last) begin
                     fcs_cnt_q <= 2'h0;
                     if (pad_en && tx_next < efh_pkg::MIN_NOFCS) begin
                        tx_st_q <= efh_pkg::EFH_T_PAD;
                     end else if (crc_en) begin
                        tx_st_q <= efh_pkg::EFH_T_FCS;
                     end else begin
                        tx_st_q <= efh_pkg::EFH_T_IDLE;
                     end
                  end
               end
            end
            efh_pkg::EFH_T_PAD: begin
               // Zero pad up to 60 bytes, folded into the CRC
               o_txd    <= 8'h00;
               tx_cnt_q <= tx_next;
               tx_crc_q <= efh_pkg::efh_crc_byte(tx_crc_q, 8'h00);
               if (tx_next >= efh_pkg::MIN_NOFCS) begin
                  tx_st_q <= efh_pkg::EFH_T_FCS;
               end
            end
            efh_pkg::EFH_T_FCS: begin
               // Complemented CRC, low byte first
               o_txd     <= ~tx_crc_q[7:0];
               tx_crc_q  <= tx_crc_q >> 8;
               fcs_cnt_q <= fcs_cnt_q + 2'h1;
               if (fcs_cnt_q == efh_pkg::FCS_LAST) begin
                  tx_st_q <= efh_pkg::EFH_T_IDLE;
               end
            end
            efh_pkg::EFH_T_DRAIN: begin
               o_tx_en <= 1'b0;
               if (tx_fire && i_txs_last) begin
                  tx_st_q <= efh_pkg::EFH_T_IDLE;
               end
            end
            default: begin
               tx_st_q <= efh_pkg::EFH_T_IDLE;
            end
         endcase
      end
   end

   // ---------------- Receive ----------------
   efh_pkg::efh_rx_st_t rx_st_q;
   logic [15:0] rx_cnt_q;
   logic [31:0] rx_crc_q;
   logic        mc_q;
   logic        bc_q;
   logic [15:0] tl_q;
   logic        rx_ok_crc;
   logic        rx_pass;
   logic        rx_big;
   logic        rx_keep;

   assign rx_ok_crc = rx_crc_q == efh_pkg::CRC_RESID;
   // Broadcast has its own enable; other multicast use the multicast one
   assign rx_pass = (!mc_q && filt_q[efh_pkg::FLT_UC]) ||
                    (mc_q && !bc_q && filt_q[efh_pkg::FLT_MC]) ||
                    (bc_q && filt_q[efh_pkg::FLT_BC]);
   assign rx_big  = !huge && rx_cnt_q >=
                    efh_pkg::HDR_LEN + efh_pkg::MAX_DATA + efh_pkg::FCS_LEN;
   // Size, class and, while checking is on, a good CRC decide keep
   assign rx_keep = rx_cnt_q >= efh_pkg::MIN_RX && rx_pass &&
                    (rx_ok_crc || !filt_q[efh_pkg::FLT_CRC]);

   // Receive sequencer; bytes after the delimiter are stored, up to 1518 while huge frames are off
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         rx_st_q     <= efh_pkg::EFH_R_IDLE;
         rx_cnt_q    <= 16'h0000;
         rx_crc_q    <= efh_pkg::CRC_INIT;
         mc_q        <= 1'b0;
         bc_q        <= 1'b0;
         tl_q        <= 16'h0000;
         o_rxb_valid <= 1'b0;
         o_rxb_data  <= 8'h00;
         o_rxb_done  <= 1'b0;
         o_rxb_keep  <= 1'b0;
         rx_stat_q   <= 22'h00_0000;
      end else begin
         o_rxb_valid <= 1'b0;
         o_rxb_done  <= 1'b0;
         o_rxb_keep  <= 1'b0;
         case (rx_st_q)
            efh_pkg::EFH_R_IDLE: begin
               if (i_rx_dv) begin
                  rx_st_q <= efh_pkg::EFH_R_PRE;
               end
            end
            efh_pkg::EFH_R_PRE: begin
               // Preamble and delimiter are swallowed here
               rx_cnt_q <= 16'h0000;
               rx_crc_q <= efh_pkg::CRC_INIT;
               bc_q     <= 1'b1;
               if (!i_rx_dv) begin
                  rx_st_q <= efh_pkg::EFH_R_IDLE;
               end else if (i_rxd == efh_pkg::SFD_BYTE) begin
                  rx_st_q <= efh_pkg::EFH_R_DATA;
               end
            end
            efh_pkg::EFH_R_DATA: begin
               if (i_rx_dv && rx_big) begin
                  o_rxb_done <= 1'b1;
                  rx_st_q    <= efh_pkg::EFH_R_DROP;
               end else if (i_rx_dv) begin
                  o_rxb_valid <= 1'b1;
                  o_rxb_data  <= i_rxd;
                  rx_cnt_q    <= rx_cnt_q + 16'h0001;
                  rx_crc_q    <= efh_pkg::efh_crc_byte(rx_crc_q, i_rxd);
                  if (rx_cnt_q == 16'h0000) begin
                     mc_q <= i_rxd[0];
                  end
                  if (rx_cnt_q < 16'h0006 && i_rxd != 8'hFF) begin
                     bc_q <= 1'b0;
                  end
                  if (rx_cnt_q == 16'h000C) begin
                     tl_q[15:8] <= i_rxd;
                  end
                  if (rx_cnt_q == 16'h000D) begin
                     tl_q[7:0] <= i_rxd;
                  end
               end else begin
                  // End of frame: decide keep or discard
                  o_rxb_done <= 1'b1;
                  o_rxb_keep <= rx_keep;
                  rx_stat_q  <= {rx_cnt_q < efh_pkg::MIN_RX, rx_keep,
                                 tl_q <= efh_pkg::MAX_DATA,
                                 bc_q, mc_q, rx_ok_crc, rx_cnt_q};
                  rx_st_q    <= efh_pkg::EFH_R_IDLE;
               end
            end
            efh_pkg::EFH_R_DROP: begin
               // Oversize: already discarded, wait out the carrier
               if (!i_rx_dv) begin
                  rx_st_q <= efh_pkg::EFH_R_IDLE;
               end
            end
            default: begin
               rx_st_q <= efh_pkg::EFH_R_IDLE;
            end
         endcase
      end
   end

   // ---------------- Checks ----------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   sequence s_pre7;
      (o_tx_en && o_txd == efh_pkg::PRE_BYTE) [*7];
   endsequence
   sequence s_sfd;
      o_tx_en && o_txd == efh_pkg::SFD_BYTE;
   endsequence
   property p_tx_pre;
      (tx_st_q == efh_pkg::EFH_T_IDLE && i_txs_valid && !o_tx_en) |=> s_pre7 ##1 s_sfd;
   endproperty
   a_tx_pre: assert property (p_tx_pre) else $error("preamble wrong");

   property p_rx_strip;
      (rx_st_q == efh_pkg::EFH_R_DATA && rx_cnt_q == 16'h0000 && i_rx_dv && !rx_big)
         |=> o_rxb_valid && o_rxb_data == $past(i_rxd);
   endproperty
   a_rx_strip: assert property (p_rx_strip) else $error("first byte not DA");

   property p_rx_mc;
      (rx_st_q == efh_pkg::EFH_R_DATA && rx_cnt_q == 16'h0000 && i_rx_dv && !rx_big)
         |=> mc_q == $past(i_rxd[0]);
   endproperty
   a_rx_mc: assert property (p_rx_mc) else $error("class bit wrong");

   property p_rx_runt;
      o_rxb_keep |-> rx_stat_q[15:0] >= efh_pkg::MIN_RX;
   endproperty
   a_rx_runt: assert property (p_rx_runt) else $error("runt kept");

   property p_rx_crc;
      (o_rxb_keep && filt_q[efh_pkg::FLT_CRC]) |-> rx_stat_q[efh_pkg::RS_CRC_OK];
   endproperty
   a_rx_crc: assert property (p_rx_crc) else $error("bad CRC kept");

   property p_rx_filt;
      o_rxb_keep |-> (rx_stat_q[efh_pkg::RS_BC] ? filt_q[efh_pkg::FLT_BC] :
                      rx_stat_q[efh_pkg::RS_MC] ? filt_q[efh_pkg::FLT_MC] :
                      filt_q[efh_pkg::FLT_UC]);
   endproperty
   a_rx_filt: assert property (p_rx_filt) else $error("class not enabled");

   property p_tx_pad;
      tx_st_q == efh_pkg::EFH_T_PAD |=> o_tx_en && o_txd == 8'h00;
   endproperty
   a_tx_pad: assert property (p_tx_pad) else $error("pad not zero");

   sequence s_fcs4;
      (tx_st_q == efh_pkg::EFH_T_FCS) [*4];
   endsequence
   property p_tx_fcs;
      (tx_st_q == efh_pkg::EFH_T_FCS && fcs_cnt_q == 2'h0)
         |-> s_fcs4 ##1 o_tx_en ##1 !o_tx_en;
   endproperty
   a_tx_fcs: assert property (p_tx_fcs) else $error("FCS not four bytes");

   property p_tx_short;
      (tx_st_q == efh_pkg::EFH_T_DATA && tx_fire && i_txs_last && !pad_en)
         |=> tx_st_q != efh_pkg::EFH_T_PAD;
   endproperty
   a_tx_short: assert property (p_tx_short) else $error("unpadded frame extended");
endmodule
`default_nettype wire

// *** tb/efh_medium.sv ***
// Remote node on the twisted pair: frames bytes toward the receiver.
// Assumes the bench loads frm[] and calls send() from its own process.
`default_nettype none
module efh_medium (
   input  wire logic       i_clk,
   output logic            o_dv,
   output logic      [7:0] o_d
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] frm [0:2047];
   logic       busy = 1'b0;
   initial o_dv = 1'b0;
   initial o_d = 8'h00;

   // Idle line toggles so a stale byte never looks like data
   always @(posedge i_clk) if (!busy) o_d <= ~o_d;

   // Preamble, delimiter, then the frame; gap of a few cycles after
   task automatic send(input int n);
      busy = 1'b1;
      for (int i = -8; i < n; i++) begin
         @(posedge i_clk);
         o_dv <= 1'b1;
         o_d  <= (i < -1) ? 8'h55 : (i == -1) ? 8'hd5 : frm[i];
      end
      @(posedge i_clk);
      o_dv <= 1'b0;
      busy = 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// *** tb/efh_frame_tb.sv ***
// Self-checking bench for frame handling: registers, transmit, receive.
// Assumes the medium model feeds receive bytes; the bench is the host.
`default_nettype none
module efh_frame_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, txv = 1'b0, txl = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, seed = 32'h0000_d3cd, rdat, hc;
   logic [7:0]  txd = 8'h00, rxd, txo, rb_d;
   logic        ack, txs_rdy, tx_en, rx_dv, rb_v, rb_done, rb_keep;
   logic        tx_chk = 1'b1;
   logic [7:0]  b [0:2047];
   logic [31:0] wbq [$];
   logic [7:0]  txq [$], rxq [$];
   logic        kq [$];
   int          fails = 0, n_checks = 0, tx_n = 0, n_done = 0, n_host = 0, nb = 0;
   localparam logic [31:0] NO_NOTE = 32'hdead_beef;
   logic [15:0] tab [10] = '{16'h400f, 16'h122f, 16'h404f, 16'h400e, 16'h402d,
                             16'h404b, 16'h404d, 16'h401f, 16'h4017, 16'h110f};

   efh_frame u_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_txs_valid(txv), .i_txs_data(txd), .i_txs_last(txl),
      .o_txs_ready(txs_rdy), .o_tx_en(tx_en), .o_txd(txo), .i_rx_dv(rx_dv), .i_rxd(rxd),
      .o_rxb_valid(rb_v), .o_rxb_data(rb_d), .o_rxb_done(rb_done), .o_rxb_keep(rb_keep));
   efh_medium u_med (.i_clk(clk), .o_dv(rx_dv), .o_d(rxd));

   // 200 MHz clock
   initial forever #2.5 clk = ~clk;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // Own reflected CRC-32, kept apart from the design's copy
   function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
      return c;
   endfunction

   // Bounded wait; running out ends the run as a mismatch
   task automatic limit(input int k, input int lim);
      if (k >= lim) begin
         fails++;
         finish_test();
      end
   endtask

   // Classic single Wishbone cycle, released only after ack is seen
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (ack) break;
      end
      limit(k, 20);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wbq.push_back(e);
      wb(1'b0, a, 32'h0000_0000, 4'hf);
   endtask

   // Random frame bytes; host supplies both addresses itself
   task automatic fill(input int n);
      for (int k = 0; k < n; k++) begin
         seed = xs(seed);
         b[k] = seed[7:0];
      end
   endtask

   // Feed the transmit stream and note every byte due on the medium
   task automatic send_tx(input int n, input logic [2:0] cfg);
      int i, k, m;
      logic [31:0] c;
      c = 32'hffff_ffff;
      m = (cfg[0] && n < 60) ? 60 : n;
      repeat (7) txq.push_back(8'h55);
      txq.push_back(8'hd5);
      for (i = 0; i < m; i++) begin
         if (i >= n) b[i] = 8'h00;
         txq.push_back(b[i]);
         c = crc_upd(c, b[i]);
      end
      for (i = 0; i < 4 && cfg != 3'h0; i++) txq.push_back(~c[8*i +: 8]);
      i = 0;
      tx_n = 0;
      @(posedge clk);
      txv <= 1'b1;
      txd <= b[0];
      txl <= (n == 1);
      for (k = 0; k < 4000 && i < n; k++) begin
         @(posedge clk);
         if (txs_rdy) begin
            i++;
            txd <= b[i];
            txl <= (i == n - 1);
            txv <= (i < n);
         end
      end
      limit(k, 4000);
      for (k = 0; k < 200 && tx_en; k++) @(posedge clk);
      limit(k, 200);
      if (tx_chk) chk(32'h0000_0000, txq.size());
   endtask

   // One received frame: class, filter, CRC and size from a table entry
   task automatic rx_case(input logic [15:0] t);
      int n, k, d0;
      logic [31:0] c;
      logic kp, bad, mc, bc, lf, en;
      n = t[15:8];
      bad = t[4];
      bc = t[6];
      fill(n);
      for (k = 0; k < 6; k++) b[k] = bc ? 8'hff : (k == 1) ? 8'h00 : b[k];
      b[0][0] = t[5] | bc;
      mc = b[0][0];
      b[12] = 8'h05;
      b[13] = seed[9] ? 8'hdc : 8'hdd;
      lf = (b[13] == 8'hdc);
      c = 32'hffff_ffff;
      for (k = 0; k < n - 4; k++) c = crc_upd(c, b[k]);
      for (k = 0; k < 4; k++) b[n-4+k] = ~c[8*k +: 8] ^ {7'h00, bad && k == 0};
      en = bc ? t[2] : mc ? t[1] : t[0];
      kp = (n >= 18) && en && (!bad || !t[3]);
      wb(1'b1, 4'h4, {28'h000_0000, t[3:0]}, 4'hf);
      for (k = 0; k < n; k++) begin
         u_med.frm[k] = b[k];
         rxq.push_back(b[k]);
      end
      kq.push_back(kp);
      d0 = n_done;
      u_med.send(n);
      for (k = 0; k < 50 && n_done == d0; k++) @(posedge clk);
      limit(k, 50);
      c = {11'h000, kp, lf, bc, mc, !bad, 16'(n)};
      if (n >= 18) rd(4'h8, c);
   endtask

   // Results are compared as they appear, oldest note first
   always @(posedge clk) begin
      if (ack && !we) chk(wbq.size() ? wbq.pop_front() : 32'hdead_beef, rdat);
      if (tx_en) tx_n++;
      if (tx_en && tx_chk) chk(txq.size() ? txq.pop_front() : NO_NOTE, txo);
      if (rb_v) chk(rxq.size() ? rxq.pop_front() : 32'hdead_beef, rb_d);
      if (rb_v) nb++;
      if (rb_done) begin
         n_done++;
         chk(kq.size() ? kq.pop_front() : 32'hdead_beef, rb_keep);
         // Host side: frames kept by the device but under 64 bytes are refused
         if (rb_keep && nb >= 64) n_host++;
         nb = 0;
      end
   end

   // Hang guard
   initial begin
      #400_000;
      fails++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(4'h0, 32'h0000_0000);
      rd(4'h4, 32'h0000_000f);
      wb(1'b1, 4'h0, 32'h0000_0001, 4'h0);
      rd(4'h0, 32'h0000_0000);
      $display("test registers done");
      for (int m = 0; m < 8; m++) begin
         fill(20);
         wb(1'b1, 4'h0, {29'h0000_0000, 3'(m)}, 4'hf);
         send_tx(20, 3'(m));
      end
      // Host pads to 60 and appends its own CRC while the device does neither
      wb(1'b1, 4'h0, 32'h0000_0000, 4'hf);
      fill(20);
      hc = 32'hffff_ffff;
      for (int k = 0; k < 64; k++) begin
         if (k >= 20 && k < 60) b[k] = 8'h00;
         if (k >= 60) b[k] = ~hc[8*(k-60) +: 8];
         else hc = crc_upd(hc, b[k]);
      end
      send_tx(64, 3'h0);
      $display("test transmit framing done");
      fill(1515);
      wb(1'b1, 4'h0, 32'h0000_0001, 4'hf);
      tx_chk = 1'b0;
      send_tx(1515, 3'h1);
      txq.delete();
      tx_chk = 1'b1;
      chk(32'h0000_0001, tx_n > 0 && tx_n < 1523);
      rd(4'hc, 32'h0000_0002);
      wb(1'b1, 4'h0, 32'h0000_0009, 4'hf);
      send_tx(1515, 3'h1);
      rd(4'hc, 32'h0000_0000);
      $display("test huge frames done");
      foreach (tab[i]) rx_case(tab[i]);
      chk(32'h0000_0004, n_host);
      // Huge frames off: cut after 1518 stored bytes and discarded at once
      wb(1'b1, 4'h0, 32'h0000_0001, 4'hf);
      fill(1519);
      for (int k = 0; k < 1519; k++) u_med.frm[k] = b[k];
      for (int k = 0; k < 1518; k++) rxq.push_back(b[k]);
      kq.push_back(1'b0);
      u_med.send(1519);
      chk(32'h0000_0000, rxq.size());
      $display("test receive done");
      finish_test();
   end
endmodule
`default_nettype wire
